// ==== core/sync_bit.v ====
`default_nettype none
module sync_bit
(
	// Clock and reset
	input  wire core_clk,
	input  wire rst,
	// Data
	input  wire asyncIn,
	output wire syncOut
);
	reg stage1_reg;
	reg stage2_reg;

	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			stage1_reg <= 1'b0;
			stage2_reg <= 1'b0;
		end
		else
		begin
			stage1_reg <= asyncIn;
			stage2_reg <= stage1_reg;
		end
	end

	assign syncOut = stage2_reg;
endmodule
`default_nettype wire

// ==== core/usb_power_and_interrupt_ctl.v ====
`include "usb_power_map.vh"
`default_nettype none
module usb_power_and_interrupt_ctl
(
	// Clock and reset
	input  wire        core_clk,
	input  wire        rst,
	// Register port
	input  wire [7:0]  regAddr,
	input  wire [7:0]  regWrData,
	input  wire        regWrite,
	input  wire        regRead,
	output reg  [7:0]  regRdData,
	// Bus-side events from the link (other domain)
	input  wire        busResetSeen,
	input  wire        busSuspendSeen,
	input  wire        busResumeSeen,
	// Same-clock events from the packet engine
	input  wire        sofPulse,
	input  wire [10:0] sofFrameNumber,
	input  wire [3:0]  inEndpointEvent,
	input  wire [3:0]  outEndpointEvent,
	input  wire        isoInLoaded,
	input  wire        isoInToken,
	// Controls to the link
	output wire        controllerEnable,
	output wire        resumeDrive,
	output wire        controllerReset,
	output reg         isoSendPacket,
	output reg         isoSendZeroLength,
	// Interrupt
	output wire        usbIrq
);
	wire       busResetSync;
	wire       suspendSync;
	wire       resumeSync;
	reg        suspendPrev_reg;
	reg        resumePrev_reg;
	reg        busResetPrev_reg;
	reg        forceReset_reg;
	reg        isoUpdate_reg;
	reg        inhibit_reg;
	reg        resume_reg;
	reg        suspendMode_reg;
	reg        suspEn_reg;
	reg [10:0] frame_reg;
	reg [3:0]  inFlags_reg;
	reg [3:0]  outFlags_reg;
	reg [3:0]  cmnFlags_reg;
	reg [3:0]  inEn_reg;
	reg [3:0]  outEn_reg;
	reg [3:0]  cmnEn_reg;
	reg [7:0]  extEn_reg;
	reg        isoPending_reg;
	reg        isoArmed_reg;
	wire       ctlRst;
	wire       suspendRise;
	wire       resumeRise;
	wire       busResetRise;
	wire       wrPower;
	wire       rdIn;
	wire       rdOut;
	wire       rdCmn;
	wire [7:0] powerView;

	sync_bit syncReset
	(
		.core_clk (core_clk),
		.rst      (rst),
		.asyncIn  (busResetSeen),
		.syncOut  (busResetSync)
	);
	sync_bit syncSuspend
	(
		.core_clk (core_clk),
		.rst      (rst),
		.asyncIn  (busSuspendSeen),
		.syncOut  (suspendSync)
	);
	sync_bit syncResume
	(
		.core_clk (core_clk),
		.rst      (rst),
		.asyncIn  (busResumeSeen),
		.syncOut  (resumeSync)
	);

	// Forced controller reset, one cycle wide, asynchronous to the USB registers
	assign ctlRst          = rst | forceReset_reg;
	assign controllerReset = forceReset_reg;
	assign wrPower         = regWrite && (regAddr == `OFF_POWER);
	assign rdIn            = regRead && (regAddr == `OFF_IN_FLAGS);
	assign rdOut           = regRead && (regAddr == `OFF_OUT_FLAGS);
	assign rdCmn           = regRead && (regAddr == `OFF_COMMON_FLAGS);
	assign suspendRise     = suspendSync & ~suspendPrev_reg;
	assign resumeRise      = resumeSync & ~resumePrev_reg;
	assign busResetRise    = busResetSync & ~busResetPrev_reg;
	assign controllerEnable = ~inhibit_reg;
	assign resumeDrive     = resume_reg;
	assign powerView = {isoUpdate_reg, 2'b00, inhibit_reg, busResetSync, resume_reg,
		suspendMode_reg, suspEn_reg};

	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			forceReset_reg   <= 1'b0;
			extEn_reg        <= 8'h00;
			suspendPrev_reg  <= 1'b0;
			resumePrev_reg   <= 1'b0;
			busResetPrev_reg <= 1'b0;
		end
		else
		begin
			forceReset_reg   <= wrPower && regWrData[`PWR_BUS_RESET];
			if (regWrite && (regAddr == `OFF_EXT_INT_EN))
				extEn_reg <= regWrData;
			suspendPrev_reg  <= suspendSync;
			resumePrev_reg   <= resumeSync;
			busResetPrev_reg <= busResetSync;
		end
	end

	always @(posedge core_clk or posedge ctlRst)
	begin
		if (ctlRst)
		begin
			isoUpdate_reg   <= 1'b0;
			inhibit_reg     <= 1'b1;
			resume_reg      <= 1'b0;
			suspendMode_reg <= 1'b0;
			suspEn_reg      <= 1'b0;
			frame_reg       <= 11'h000;
			inFlags_reg     <= 4'h0;
			outFlags_reg    <= 4'h0;
			cmnFlags_reg    <= 4'h0;
			inEn_reg        <= `IN_EN_RESET;
			outEn_reg       <= `OUT_EN_RESET;
			cmnEn_reg       <= `CMN_EN_RESET;
			isoPending_reg  <= 1'b0;
			isoArmed_reg    <= 1'b0;
		end
		else
		begin
			if (wrPower)
			begin
				isoUpdate_reg <= regWrData[`PWR_ISO_UPDATE];
				suspEn_reg    <= regWrData[`PWR_SUSP_EN];
				resume_reg    <= regWrData[`PWR_RESUME];
				if (!regWrData[`PWR_INHIBIT])
					inhibit_reg <= 1'b0;
			end
			// Suspend entry and exit
			if (suspendRise && suspEn_reg)
				suspendMode_reg <= 1'b1;
			else if (resumeRise || busResetRise || (wrPower && resume_reg && !regWrData[`PWR_RESUME]))
				suspendMode_reg <= 1'b0;
			if (sofPulse)
				frame_reg <= sofFrameNumber;
			if (regWrite && (regAddr == `OFF_IN_ENABLE))
				inEn_reg <= regWrData[3:0];
			if (regWrite && (regAddr == `OFF_OUT_ENABLE))
				outEn_reg <= regWrData[3:0];
			if (regWrite && (regAddr == `OFF_COMMON_ENABLE))
				cmnEn_reg <= regWrData[3:0];
			// Read clears, new event wins; no write touches flags except a POWER write whose forced reset clears them
			inFlags_reg  <= (rdIn ? 4'h0 : inFlags_reg) | inEndpointEvent;
			outFlags_reg <= (rdOut ? 4'h0 : outFlags_reg) | outEndpointEvent;
			cmnFlags_reg <= (rdCmn ? 4'h0 : cmnFlags_reg) |
				{sofPulse, busResetRise, resumeRise, suspendRise && suspEn_reg};
			// Bus reset restores the interrupt enables to their reset values, OUT endpoint 0 and suspend excluded
			if (busResetRise)
			begin
				inEn_reg  <= `IN_EN_RESET;
				outEn_reg <= `OUT_EN_RESET;
				cmnEn_reg <= `CMN_EN_BUSRST;
			end
			// ISO hold until next SOF
			if (isoInLoaded)
			begin
				isoPending_reg <= 1'b1;
				isoArmed_reg   <= ~isoUpdate_reg;
			end
			else if (sofPulse && isoPending_reg)
				isoArmed_reg <= 1'b1;
			if (isoInToken && isoArmed_reg && !isoInLoaded)
			begin
				isoPending_reg <= 1'b0;
				isoArmed_reg   <= 1'b0;
			end
		end
	end

	always @(posedge core_clk or posedge ctlRst)
	begin
		if (ctlRst)
		begin
			isoSendPacket     <= 1'b0;
			isoSendZeroLength <= 1'b0;
		end
		else
		begin
			isoSendPacket     <= isoInToken && isoArmed_reg;
			isoSendZeroLength <= isoInToken && !isoArmed_reg;
		end
	end

	// Flagged and enabled, then system enable
	assign usbIrq = extEn_reg[`EXT_USB_EN_BIT] &&
		(|(inFlags_reg & inEn_reg) || |(outFlags_reg & outEn_reg) || |(cmnFlags_reg & cmnEn_reg));

	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
			regRdData <= 8'h00;
		else if (!regRead)
			regRdData <= 8'h00;
		else if (regAddr == `OFF_POWER)
			regRdData <= powerView;
		else if (regAddr == `OFF_IN_FLAGS)
			regRdData <= {4'h0, inFlags_reg};
		else if (regAddr == `OFF_OUT_FLAGS)
			regRdData <= {4'h0, outFlags_reg};
		else if (regAddr == `OFF_COMMON_FLAGS)
			regRdData <= {4'h0, cmnFlags_reg};
		else if (regAddr == `OFF_IN_ENABLE)
			regRdData <= {4'h0, inEn_reg};
		else if (regAddr == `OFF_OUT_ENABLE)
			regRdData <= {4'h0, outEn_reg};
		else if (regAddr == `OFF_COMMON_ENABLE)
			regRdData <= {4'h0, cmnEn_reg};
		else if (regAddr == `OFF_FRAME_LOW)
			regRdData <= frame_reg[7:0];
		else if (regAddr == `OFF_FRAME_HIGH)
			regRdData <= {5'h00, frame_reg[10:8]};
		else if (regAddr == `OFF_EXT_INT_EN)
			regRdData <= extEn_reg;
		else
			regRdData <= 8'h00;
	end
endmodule
`default_nettype wire

// ==== core/usb_power_map.vh ====
`ifndef USB_POWER_MAP_VH
`define USB_POWER_MAP_VH
// Register offsets (8-bit register space)
`define OFF_POWER       8'h01
`define OFF_IN_FLAGS    8'h02
`define OFF_OUT_FLAGS   8'h04
`define OFF_COMMON_FLAGS 8'h06
`define OFF_IN_ENABLE   8'h07
`define OFF_OUT_ENABLE  8'h09
`define OFF_COMMON_ENABLE 8'h0b
`define OFF_FRAME_LOW   8'h0c
`define OFF_FRAME_HIGH  8'h0d
`define OFF_EXT_INT_EN  8'h10
// Power control fields
`define PWR_ISO_UPDATE  7
`define PWR_INHIBIT     4
`define PWR_BUS_RESET   3
`define PWR_RESUME      2
`define PWR_SUSPEND     1
`define PWR_SUSP_EN     0
`define PWR_RESET_VAL   8'h10
`define PWR_RW_MASK     8'h95
// Flag and enable layout
`define FLAG_WIDTH      4
`define CMN_SUSPEND     0
`define CMN_RESUME      1
`define CMN_RESET       2
`define CMN_SOF         3
`define IN_EN_RESET     4'hf
`define OUT_EN_RESET    4'he
`define CMN_EN_RESET    4'he
`define CMN_EN_BUSRST   4'he
`define EXT_USB_EN_BIT  1
`endif

// ==== verification/usb_host_model.sv ====
`default_nettype none
module usb_host_model
(
	// Clock
	input  wire logic        core_clk,
	// Bus levels
	output logic        busResetSeen,
	output logic        busSuspendSeen,
	output logic        busResumeSeen,
	// Frames
	output logic        sofPulse,
	output logic [10:0] sofFrameNumber
);
	timeunit 1ns;
	timeprecision 100ps;
	initial {busResetSeen, busSuspendSeen, busResumeSeen, sofPulse, sofFrameNumber} = 0;
	// Level held until the synchroniser has it
	task sig(input logic [2:0] v);
		{busResetSeen, busSuspendSeen, busResumeSeen} <= v;
		repeat (4) @(posedge core_clk);
	endtask
	task sof(input logic [10:0] n);
		sofFrameNumber <= n;
		sofPulse <= 1'h1;
		@(posedge core_clk);
		sofPulse <= 1'h0;
		// Number not held after the marker
		sofFrameNumber <= ~n;
	endtask
endmodule
`default_nettype wire

// ==== verification/usb_power_and_interrupt_ctl_props.sv ====
`default_nettype none
module usb_power_and_interrupt_ctl_props
(
	// Clock and reset
	input wire logic       core_clk,
	input wire logic       rst,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic       regWrite,
	input wire logic       regRead,
	input wire logic [7:0] regRdData,
	// Controls
	input wire logic       isoInToken,
	input wire logic       controllerEnable,
	input wire logic       resumeDrive,
	input wire logic       controllerReset,
	input wire logic       isoSendPacket,
	input wire logic       isoSendZeroLength,
	input wire logic       usbIrq
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	wire pwrWr = regWrite && regAddr == 8'h01;
	rd_idle_a: assert property (!$past(regRead) |-> regRdData == 8'h00) else $error("stray read data");
	iso_answer_a: assert property (isoInToken |=> isoSendPacket != isoSendZeroLength) else $error("no iso answer");
	iso_quiet_a: assert property (!$past(isoInToken) |-> !isoSendPacket && !isoSendZeroLength) else $error("iso unasked");
	force_reset_a: assert property (pwrWr && regWrData[3] |=> controllerReset) else $error("no forced reset");
	reset_pulse_a: assert property (controllerReset |=> !controllerReset) else $error("reset pulse long");
	inhibit_reset_a: assert property (controllerReset |=> !controllerEnable) else $error("not inhibited");
	enable_write_a: assert property ($rose(controllerEnable) |-> $past(pwrWr && !regWrData[4])) else $error("enable unasked");
	resume_write_a: assert property (pwrWr && !regWrData[3] |=> resumeDrive == $past(regWrData[2])) else $error("resume");
	irq_gate_a: assert property (regWrite && regAddr == 8'h10 && !regWrData[1] |=> !usbIrq) else $error("irq ungated");
	cover property (isoSendPacket);
	cover property (isoSendZeroLength);
	cover property ($rose(usbIrq));
endmodule
bind usb_power_and_interrupt_ctl usb_power_and_interrupt_ctl_props u_props
(
	.core_clk, .rst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .isoInToken, .controllerEnable,
	.resumeDrive, .controllerReset, .isoSendPacket, .isoSendZeroLength, .usbIrq
);
`default_nettype wire

// ==== verification/usb_power_and_interrupt_ctl_tb_top.sv ====
`default_nettype none
module usb_power_and_interrupt_ctl_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        core_clk, rst, regWrite, regRead, isoInLoaded, isoInToken;
	logic [7:0]  regAddr, regWrData, regRdData;
	logic [3:0]  inEndpointEvent, outEndpointEvent;
	logic        busResetSeen, busSuspendSeen, busResumeSeen, sofPulse;
	logic [10:0] sofFrameNumber;
	logic        controllerEnable, resumeDrive, controllerReset, isoSendPacket, isoSendZeroLength, usbIrq;
	int          nMismatch, samplesChecked;
	logic [15:0] rows [5] = '{16'h0110, 16'h070f, 16'h090e, 16'h0b0e, 16'h3000};
	usb_host_model u_host (.core_clk(core_clk), .busResetSeen(busResetSeen), .busSuspendSeen(busSuspendSeen),
		.busResumeSeen(busResumeSeen), .sofPulse(sofPulse), .sofFrameNumber(sofFrameNumber));
	usb_power_and_interrupt_ctl u_dut (.core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .busResetSeen(busResetSeen),
		.busSuspendSeen(busSuspendSeen), .busResumeSeen(busResumeSeen), .sofPulse(sofPulse),
		.sofFrameNumber(sofFrameNumber), .inEndpointEvent(inEndpointEvent), .outEndpointEvent(outEndpointEvent),
		.isoInLoaded(isoInLoaded), .isoInToken(isoInToken), .controllerEnable(controllerEnable),
		.resumeDrive(resumeDrive), .controllerReset(controllerReset), .isoSendPacket(isoSendPacket),
		.isoSendZeroLength(isoSendZeroLength), .usbIrq(usbIrq));
	always #4 core_clk = ~core_clk;
	task cmp(input logic [7:0] g, e);
		samplesChecked++;
		if (g !== e)
		begin
			nMismatch++;
			$display("FAIL %0t got %h exp %h", $time, g, e);
		end
	endtask
	task summarize;
		$display("checked %0d mismatched %0d", samplesChecked, nMismatch);
		if (nMismatch == 0 && samplesChecked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task wr(input logic [7:0] a, d);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'h1;
		@(posedge core_clk);
		regWrite <= 1'h0;
		// Let an edge pass so a following write never re-raises the strobe in this step
		@(posedge core_clk);
	endtask
	task rd(input logic [7:0] a, e);
		regAddr <= a;
		regRead <= 1'h1;
		@(posedge core_clk);
		regRead <= 1'h0;
		@(negedge core_clk);
		cmp(regRdData, e);
		@(posedge core_clk);
	endtask
	task irq(input logic q);
		@(negedge core_clk);
		cmp(8'(usbIrq), 8'(q));
		@(posedge core_clk);
	endtask
	task ev(input logic [3:0] i, o);
		inEndpointEvent <= i;
		outEndpointEvent <= o;
		@(posedge core_clk);
		inEndpointEvent <= 4'h0;
		outEndpointEvent <= 4'h0;
	endtask
	task iso(input logic ld, s, input logic [1:0] e);
		isoInLoaded <= ld;
		@(posedge core_clk);
		isoInLoaded <= 1'h0;
		if (s)
			u_host.sof(11'h001);
		isoInToken <= 1'h1;
		@(posedge core_clk);
		isoInToken <= 1'h0;
		@(negedge core_clk);
		cmp(8'({isoSendPacket, isoSendZeroLength}), 8'(e));
		@(posedge core_clk);
	endtask
	initial
	begin
		core_clk = 0;
		rst = 1;
		{regAddr, regWrData, regWrite, regRead, inEndpointEvent, outEndpointEvent, isoInLoaded, isoInToken} = 0;
		repeat (2) @(posedge core_clk);
		rst <= 1'h0;
		@(negedge core_clk);
		cmp(8'(controllerEnable), 8'h00);
		@(posedge core_clk);
		for (int i = 0; i < 5; i++)
			rd(rows[i][15:8], rows[i][7:0]);
		$display("test reset done");
		wr(8'h10, 8'h02);
		ev(4'h5, 4'h0);
		irq(1'h1);
		wr(8'h02, 8'hff);
		rd(8'h02, 8'h05);
		irq(1'h0);
		rd(8'h02, 8'h00);
		wr(8'h07, 8'h00);
		ev(4'h2, 4'h0);
		irq(1'h0);
		rd(8'h02, 8'h02);
		ev(4'h0, 4'h2);
		wr(8'h10, 8'h00);
		irq(1'h0);
		wr(8'h10, 8'h02);
		irq(1'h1);
		rd(8'h04, 8'h02);
		$display("test flags done");
		u_host.sof(11'h5a3);
		wr(8'h0c, 8'h00);
		rd(8'h0c, 8'ha3);
		rd(8'h0d, 8'h05);
		rd(8'h06, 8'h08);
		$display("test frame done");
		wr(8'h01, 8'h01);
		u_host.sig(3'h2);
		rd(8'h01, 8'h03);
		rd(8'h06, 8'h01);
		u_host.sig(3'h1);
		rd(8'h01, 8'h01);
		rd(8'h06, 8'h02);
		u_host.sig(3'h2);
		u_host.sig(3'h0);
		wr(8'h01, 8'h05);
		rd(8'h01, 8'h07);
		// Wake length shortened, the count is software's
		repeat (20) @(posedge core_clk);
		wr(8'h01, 8'h00);
		rd(8'h01, 8'h00);
		$display("test suspend done");
		u_host.sig(3'h4);
		rd(8'h01, 8'h08);
		// Suspend flag from the second suspend is still unread
		rd(8'h06, 8'h05);
		u_host.sig(3'h0);
		wr(8'h07, 8'h00);
		wr(8'h01, 8'h08);
		@(posedge core_clk);
		rd(8'h01, 8'h10);
		rd(8'h07, 8'h0f);
		@(negedge core_clk);
		cmp(8'(controllerEnable), 8'h00);
		@(posedge core_clk);
		$display("test forced reset done");
		wr(8'h01, 8'h00);
		iso(1'h1, 1'h0, 2'h2);
		wr(8'h01, 8'h80);
		iso(1'h1, 1'h0, 2'h1);
		iso(1'h1, 1'h1, 2'h2);
		iso(1'h0, 1'h0, 2'h1);
		$display("test iso done");
		// Full reset also clears the system enable, unlike the forced one
		rst <= 1'h1;
		repeat (2) @(posedge core_clk);
		rst <= 1'h0;
		rd(8'h10, 8'h00);
		rd(8'h01, 8'h10);
		$display("test mid-run reset done");
		summarize();
	end
	initial
	begin
		#100us;
		nMismatch++;
		summarize();
	end
endmodule
`default_nettype wire
